/* File: rtl/nov_pkg.sv */
package nov_pkg;

	// Clock and protection-cycle timing.
	localparam int CLK_MHZ       = 250;
	localparam int CYCLE_TIME_US = 5000;
	localparam int CYCLE_CLKS    = CYCLE_TIME_US * CLK_MHZ;
	localparam int CYC_W         = 21;

	// Operating-time settings are kept in protection-cycle steps.
	localparam int STEP_TIME_MS    = 5;
	localparam int DT_DEFAULT_MS   = 40;
	localparam int DT_DEFAULT_STEP = DT_DEFAULT_MS / STEP_TIME_MS;

	// Datapath widths.
	localparam int PH_W   = 16;
	localparam int SUM_W  = 18;
	localparam int SQ_W   = 38;
	localparam int ROOT_W = 19;
	localparam int MEAS_W = 20;
	localparam int THR_W  = 14;
	localparam int TIME_W = 20;
	localparam int K_W    = 13;
	localparam int VT_W   = 24;
	localparam int DIV_W  = 40;
	localparam int DCNT_W = 6;
	localparam int CTRL_W = 9;
	localparam int INT_W  = 3;

	// Scaling constants: 1/sqrt(3) in 16-bit fraction, hysteresis 97/100.
	localparam logic [16:0]      INV_SQRT3   = 17'h093cd;
	localparam int               INV_SHIFT   = 16;
	localparam logic [6:0]       HYST_NUM    = 7'h61;
	localparam logic [6:0]       PCT_SCALE   = 7'h64;
	localparam logic [DIV_W-1:0] PRIM_DIV    = 40'h00000003e8;
	localparam logic [TIME_W-1:0] TIME_MAX   = 20'h57e40;
	localparam logic [TIME_W-1:0] RATIO_MAX  = 20'h1e848;
	localparam logic [DCNT_W-1:0] DIV_STEPS  = 6'h28;

	// Reset values.
	localparam logic [THR_W-1:0]  THR_RST  = 14'h07d0;
	localparam logic [TIME_W-1:0] DLY_RST  = TIME_W'(DT_DEFAULT_STEP);
	localparam logic [K_W-1:0]    K_RST    = 13'h0005;
	localparam logic [VT_W-1:0]   VT_RST   = 24'h002710;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h080;

	// Control register field positions.
	localparam int CTRL_SRC_LSB   = 0;
	localparam int CTRL_FORCE_LSB = 2;
	localparam int CTRL_FORCE_EN  = 4;
	localparam int CTRL_AUXA_MODE = 5;
	localparam int CTRL_AUXB_MODE = 6;
	localparam int CTRL_LN_CONN   = 7;
	localparam int CTRL_INVERSE_DELAY_MODE      = 8;

	// Interrupt bit positions.
	localparam int INT_START   = 0;
	localparam int INT_TRIP    = 1;
	localparam int INT_BLOCKED = 2;

	// Register byte offsets.
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] REG_THR_G0    = 8'h04;
	localparam logic [ADDR_W-1:0] REG_THR_G1    = 8'h08;
	localparam logic [ADDR_W-1:0] REG_GROUP     = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_DLY_G0    = 8'h10;
	localparam logic [ADDR_W-1:0] REG_DLY_G1    = 8'h14;
	localparam logic [ADDR_W-1:0] REG_K_G0      = 8'h18;
	localparam logic [ADDR_W-1:0] REG_K_G1      = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_VT_CALC   = 8'h20;
	localparam logic [ADDR_W-1:0] REG_VT_AUX_A  = 8'h24;
	localparam logic [ADDR_W-1:0] REG_VT_AUX_B  = 8'h28;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h2c;
	localparam logic [ADDR_W-1:0] REG_RATIO     = 8'h30;
	localparam logic [ADDR_W-1:0] REG_EXPECTED  = 8'h34;
	localparam logic [ADDR_W-1:0] REG_REMAINING = 8'h38;
	localparam logic [ADDR_W-1:0] REG_PRIMARY   = 8'h3c;
	localparam logic [ADDR_W-1:0] REG_INT_STAT  = 8'h40;
	localparam logic [ADDR_W-1:0] REG_INT_MASK  = 8'h44;
	localparam logic [ADDR_W-1:0] REG_MEAS      = 8'h48;

	typedef enum logic [1:0] {
		SRC_NONE  = 2'b00,
		SRC_CALC  = 2'b01,
		SRC_AUX_A = 2'b10,
		SRC_AUX_B = 2'b11
	} nov_src_t;

	typedef enum logic [1:0] {
		FORCE_NORMAL  = 2'b00,
		FORCE_START   = 2'b01,
		FORCE_TRIP    = 2'b10,
		FORCE_BLOCKED = 2'b11
	} nov_force_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_TIMING  = 2'b01,
		ST_TRIPPED = 2'b10,
		ST_BLOCKED = 2'b11
	} nov_state_t;

endpackage : nov_pkg

/* File: rtl/nov_divider.sv */
`timescale 1ns/1ns
module nov_divider import nov_pkg::*; (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             reset,
	// Request.
	input  wire logic             start,
	input  wire logic [DIV_W-1:0] dividend,
	input  wire logic [DIV_W-1:0] divisor,
	// Answer.
	output logic                  busy,
	output logic                  done,
	output logic [DIV_W-1:0]      quotient
);

	typedef struct packed {
		logic              busy;
		logic              done;
		logic [DCNT_W-1:0] cnt;
		logic [DIV_W-1:0]  quo;
		logic [DIV_W:0]    rem;
		logic [DIV_W-1:0]  dsr;
	} nov_div_state_t;

	nov_div_state_t r;
	nov_div_state_t n;
	logic [DIV_W:0] trial;

	// One restoring step per clock; a zero divisor yields all ones.
	always_comb begin
		n = r;
		n.done = 1'b0;
		trial = {r.rem[DIV_W-1:0], r.quo[DIV_W-1]};
		if (start && !r.busy) begin
			n.busy = 1'b1;
			n.cnt  = DIV_STEPS;
			n.quo  = dividend;
			n.rem  = '0;
			n.dsr  = divisor;
		end else if (r.busy) begin
			if (trial >= {1'b0, r.dsr}) begin
				n.rem = trial - {1'b0, r.dsr};
				n.quo = {r.quo[DIV_W-2:0], 1'b1};
			end else begin
				n.rem = trial;
				n.quo = {r.quo[DIV_W-2:0], 1'b0};
			end
			n.cnt = r.cnt - 6'h01;
			if (r.cnt == 6'h01) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign busy     = r.busy;
	assign done     = r.done;
	assign quotient = r.quo;

endmodule : nov_divider

/* File: rtl/nov_stage.sv */
// Overview of operation
// - Calculated residual is third of phasor sum.
// - Residual scaled to line-to-line percent level.
// - Inputs are fundamental phasors and RMS magnitudes.
// - Static source select: none, calculated, A, B.
// - Aux channels usable only in residual mode.
// - Status force applies only when forcing enabled.
// - Select and force settings ignore setting groups.
// - Pick-up when magnitude exceeds the threshold.
// - Release below 97 percent of threshold.
// - Report measured to threshold ratio, 0.01 steps.
// - Threshold in 0.01 percent steps, default 20.
// - Threshold and timing come from active group.
// - Unselected source falls back or reports none.
// - Expected operating time in 5 ms steps.
// - Signed remaining time counts down to trip.
// - Pick-up level reported in primary 0.1 V.
// - Blocking at pick-up gives blocked, else start.
// - Definite delay trips after delay; zero instant.
`timescale 1ns/1ns
module nov_stage import nov_pkg::*; #(
	parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              reset,
	// Avalon-MM register slave.
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Phase-to-neutral fundamental phasors, 0.01 percent units.
	input  wire logic [PH_W-1:0]   ul1_re,
	input  wire logic [PH_W-1:0]   ul1_im,
	input  wire logic [PH_W-1:0]   ul2_re,
	input  wire logic [PH_W-1:0]   ul2_im,
	input  wire logic [PH_W-1:0]   ul3_re,
	input  wire logic [PH_W-1:0]   ul3_im,
	// Residual-mode auxiliary channel magnitudes.
	input  wire logic [MEAS_W-1:0] aux_channel_a,
	input  wire logic [MEAS_W-1:0] aux_channel_b,
	// Blocking matrix input, asynchronous.
	input  wire logic              block_in,
	// Stage outputs.
	output logic                   start_out,
	output logic                   trip_out,
	output logic                   blocked_out,
	output logic                   no_residual_available,
	output logic [1:0]             measuring_now,
	output logic                   irq
);

	typedef struct packed {
		logic [1:0]        blk_sync;
		logic [CYC_W-1:0]  cyc;
		logic [CTRL_W-1:0] ctrl;
		logic [THR_W-1:0]  thr0;
		logic [THR_W-1:0]  thr1;
		logic              grp;
		logic [TIME_W-1:0] dly0;
		logic [TIME_W-1:0] dly1;
		logic [K_W-1:0]    k0;
		logic [K_W-1:0]    k1;
		logic [VT_W-1:0]   vt_calc;
		logic [VT_W-1:0]   vt_a;
		logic [VT_W-1:0]   vt_b;
		logic [INT_W-1:0]  int_stat;
		logic [INT_W-1:0]  int_mask;
		logic              resp;
		logic [31:0]       rdata;
		logic [MEAS_W-1:0] meas;
		nov_src_t          src;
		logic              pickup;
		nov_state_t        st;
		logic [TIME_W-1:0] elapsed;
		logic [TIME_W-1:0] ratio;
		logic [TIME_W-1:0] inverse_delay_mode_t;
		logic [TIME_W:0]   remaining;
		logic [31:0]       primary;
		logic [1:0]        seq_op;
		logic              seq_busy;
		logic              div_start;
		logic              start_o;
		logic              trip_o;
		logic              blocked_o;
		logic              irq_o;
	} nov_top_state_t;

	nov_top_state_t r;
	nov_top_state_t n;

	logic [SUM_W-1:0]    sum_re;
	logic [SUM_W-1:0]    sum_im;
	logic [SQ_W-1:0]     sum_sq;
	logic [ROOT_W-1:0]   root;
	logic [35:0]         scaled;
	logic [MEAS_W-1:0]   meas_calc;
	nov_src_t            src_sel;
	nov_src_t            src_use;
	logic [MEAS_W-1:0]   meas_sel;
	logic [THR_W-1:0]    thr_act;
	logic [TIME_W-1:0]   dly_act;
	logic [K_W-1:0]      k_act;
	logic [VT_W-1:0]     vt_sel;
	logic [TIME_W-1:0]   target;
	logic                tick;
	logic                blk;
	logic                pick_n;
	logic [27:0]         meas_pct;
	logic [27:0]         thr_hyst;
	logic [DIV_W-1:0]    div_dividend;
	logic [DIV_W-1:0]    div_divisor;
	logic                div_busy;
	logic                div_done;
	logic [DIV_W-1:0]    div_quo;
	logic                bus_wr;
	logic [INT_W-1:0]    int_set;
	logic [INT_W-1:0]    int_clr;
	logic [31:0]         rd_mux;

	// Integer square root, one result bit per iteration.
	function automatic logic [ROOT_W-1:0] nov_isqrt(input logic [SQ_W-1:0] v);
		logic [SQ_W-1:0] x;
		logic [SQ_W-1:0] res;
		logic [SQ_W-1:0] b;
		x   = v;
		res = '0;
		b   = {2'b01, {(SQ_W-2){1'b0}}};
		for (int i = 0; i < ROOT_W; i++) begin
			if (x >= res + b) begin
				x   = x - res - b;
				res = (res >> 1) + b;
			end else begin
				res = res >> 1;
			end
			b = b >> 2;
		end
		return res[ROOT_W-1:0];
	endfunction : nov_isqrt

	// phasor sum
	// The 1/3 of the sum and the sqrt(3) lift to line level fold into one 1/sqrt(3) factor.
	assign sum_re    = SUM_W'($signed(ul1_re)) + SUM_W'($signed(ul2_re)) + SUM_W'($signed(ul3_re));
	assign sum_im    = SUM_W'($signed(ul1_im)) + SUM_W'($signed(ul2_im)) + SUM_W'($signed(ul3_im));
	// Operands are widened before the product so the square never wraps at the sum width.
	assign sum_sq    = SQ_W'($signed(sum_re)) * SQ_W'($signed(sum_re))
	                 + SQ_W'($signed(sum_im)) * SQ_W'($signed(sum_im));
	assign root      = nov_isqrt(sum_sq);
	assign scaled    = 36'(root) * 36'(INV_SQRT3);
	assign meas_calc = scaled[INV_SHIFT +: MEAS_W];

	assign src_sel = nov_src_t'(r.ctrl[CTRL_SRC_LSB +: 2]);

	// default fallback
	// A channel not in residual mode is never used, even when picked explicitly.
	always_comb begin
		unique case (src_sel)
			SRC_NONE: begin
				if (r.ctrl[CTRL_LN_CONN]) begin
					src_use = SRC_CALC;
				end else if (r.ctrl[CTRL_AUXA_MODE]) begin
					src_use = SRC_AUX_A;
				end else if (r.ctrl[CTRL_AUXB_MODE]) begin
					src_use = SRC_AUX_B;
				end else begin
					src_use = SRC_NONE;
				end
			end
			SRC_CALC:  src_use = r.ctrl[CTRL_LN_CONN] ? SRC_CALC : SRC_NONE;
			SRC_AUX_A: src_use = r.ctrl[CTRL_AUXA_MODE] ? SRC_AUX_A : SRC_NONE;
			SRC_AUX_B: src_use = r.ctrl[CTRL_AUXB_MODE] ? SRC_AUX_B : SRC_NONE;
		endcase
	end

	always_comb begin
		unique case (src_use)
			SRC_NONE:  meas_sel = '0;
			SRC_CALC:  meas_sel = meas_calc;
			SRC_AUX_A: meas_sel = aux_channel_a;
			SRC_AUX_B: meas_sel = aux_channel_b;
		endcase
	end

	assign thr_act = r.grp ? r.thr1 : r.thr0;
	assign dly_act = r.grp ? r.dly1 : r.dly0;
	assign k_act   = r.grp ? r.k1 : r.k0;

	always_comb begin
		unique case (r.src)
			SRC_NONE:  vt_sel = '0;
			SRC_CALC:  vt_sel = r.vt_calc;
			SRC_AUX_A: vt_sel = r.vt_a;
			SRC_AUX_B: vt_sel = r.vt_b;
		endcase
	end

	// expected time
	// Inverse mode uses the last computed value, so it lags the measurement by one cycle.
	assign target = r.ctrl[CTRL_INVERSE_DELAY_MODE] ? r.inverse_delay_mode_t : dly_act;

	// Protection cycle strobe and the second stage of the blocking synchroniser.
	assign tick = (r.cyc == CYC_W'(CYCLE_CLKS_P - 1));
	assign blk  = r.blk_sync[1];

	assign meas_pct = 28'(meas_sel) * 28'(PCT_SCALE);
	assign thr_hyst = 28'(thr_act) * 28'(HYST_NUM);
	always_comb begin
		if (src_use == SRC_NONE) begin
			pick_n = 1'b0;
		end else if (!r.pickup) begin
			pick_n = (meas_sel > MEAS_W'(thr_act));
		end else begin
			pick_n = !(meas_pct < thr_hyst);
		end
	end

	// Operand selection for the shared divider: ratio, inverse time, primary level.
	always_comb begin
		unique case (r.seq_op)
			2'b00: begin
				div_dividend = DIV_W'(r.meas) * DIV_W'(PCT_SCALE);
				div_divisor  = DIV_W'(thr_act);
			end
			2'b01: begin
				div_dividend = DIV_W'({k_act, 1'b0}) * DIV_W'(thr_act);
				div_divisor  = DIV_W'(r.meas) - DIV_W'(thr_act);
			end
			2'b10: begin
				div_dividend = DIV_W'(thr_act) * DIV_W'(vt_sel);
				div_divisor  = PRIM_DIV;
			end
			default: begin
				div_dividend = '0;
				div_divisor  = '0;
			end
		endcase
	end

	nov_divider u_div (
		.clk      (clk),
		.reset    (reset),
		.start    (r.div_start),
		.dividend (div_dividend),
		.divisor  (div_divisor),
		.busy     (div_busy),
		.done     (div_done),
		.quotient (div_quo)
	);

	// Bus write strobe and interrupt clear.
	assign bus_wr  = avs_write && r.resp;
	assign int_clr = (bus_wr && avs_address == REG_INT_STAT) ? avs_writedata[INT_W-1:0] : '0;

	// Read data multiplexer.
	always_comb begin
		case (avs_address)
			REG_CTRL:      rd_mux = 32'(r.ctrl);
			REG_THR_G0:    rd_mux = 32'(r.thr0);
			REG_THR_G1:    rd_mux = 32'(r.thr1);
			REG_GROUP:     rd_mux = 32'(r.grp);
			REG_DLY_G0:    rd_mux = 32'(r.dly0);
			REG_DLY_G1:    rd_mux = 32'(r.dly1);
			REG_K_G0:      rd_mux = 32'(r.k0);
			REG_K_G1:      rd_mux = 32'(r.k1);
			REG_VT_CALC:   rd_mux = 32'(r.vt_calc);
			REG_VT_AUX_A:  rd_mux = 32'(r.vt_a);
			REG_VT_AUX_B:  rd_mux = 32'(r.vt_b);
			REG_STATUS:    rd_mux = 32'({r.src == SRC_NONE, r.pickup, r.src, r.st,
			                             r.blocked_o, r.trip_o, r.start_o});
			REG_RATIO:     rd_mux = 32'(r.ratio);
			REG_EXPECTED:  rd_mux = 32'(target);
			REG_REMAINING: rd_mux = 32'($signed(r.remaining));
			REG_PRIMARY:   rd_mux = r.primary;
			REG_INT_STAT:  rd_mux = 32'(r.int_stat);
			REG_INT_MASK:  rd_mux = 32'(r.int_mask);
			REG_MEAS:      rd_mux = 32'(r.meas);
			default:       rd_mux = '0;
		endcase
	end

	// Next-state logic for the whole stage.
	always_comb begin
		n = r;
		n.div_start = 1'b0;
		n.blk_sync  = {r.blk_sync[0], block_in};
		n.cyc       = tick ? '0 : r.cyc + 21'h000001;
		// One wait state: read data lands on the edge that ends waitrequest, the write effect one edge later.
		n.resp      = (avs_read || avs_write) && !r.resp;
		if (avs_read && !r.resp) begin
			n.rdata = rd_mux;
		end
		if (bus_wr) begin
			case (avs_address)
				REG_CTRL:     n.ctrl    = avs_writedata[CTRL_W-1:0];
				REG_THR_G0:   n.thr0    = avs_writedata[THR_W-1:0];
				REG_THR_G1:   n.thr1    = avs_writedata[THR_W-1:0];
				REG_GROUP:    n.grp     = avs_writedata[0];
				REG_DLY_G0:   n.dly0    = avs_writedata[TIME_W-1:0];
				REG_DLY_G1:   n.dly1    = avs_writedata[TIME_W-1:0];
				REG_K_G0:     n.k0      = avs_writedata[K_W-1:0];
				REG_K_G1:     n.k1      = avs_writedata[K_W-1:0];
				REG_VT_CALC:  n.vt_calc = avs_writedata[VT_W-1:0];
				REG_VT_AUX_A: n.vt_a    = avs_writedata[VT_W-1:0];
				REG_VT_AUX_B: n.vt_b    = avs_writedata[VT_W-1:0];
				REG_INT_MASK: n.int_mask = avs_writedata[INT_W-1:0];
				default: ;
			endcase
		end
		if (tick) begin
			n.meas     = meas_sel;
			n.src      = src_use;
			n.pickup   = pick_n;
			n.seq_op   = 2'b00;
			n.seq_busy = 1'b1;
			n.div_start = 1'b1;
			unique case (r.st)
				ST_IDLE: begin
					n.elapsed = '0;
					if (pick_n) begin
						if (blk) begin
							n.st = ST_BLOCKED;
						end else if (target == '0) begin
							n.st = ST_TRIPPED;
						end else begin
							n.st = ST_TIMING;
						end
					end
				end
				ST_TIMING: begin
					if (!pick_n || blk) begin
						n.st = ST_IDLE;
					end else begin
						n.elapsed = r.elapsed + 20'h00001;
						if (r.elapsed + 20'h00001 >= target) begin
							n.st = ST_TRIPPED;
						end
					end
				end
				ST_TRIPPED: n.st = pick_n ? ST_TRIPPED : ST_IDLE;
				ST_BLOCKED: n.st = pick_n ? ST_BLOCKED : ST_IDLE;
			endcase
		end
		// Divider results, then the next operation in the chain.
		if (div_done && r.seq_busy) begin
			unique case (r.seq_op)
				2'b00: begin
					n.ratio = (div_quo > DIV_W'(RATIO_MAX)) ? RATIO_MAX : div_quo[TIME_W-1:0];
					n.seq_op = 2'b01;
					n.div_start = 1'b1;
				end
				2'b01: begin
					if (r.meas <= MEAS_W'(thr_act) || div_quo > DIV_W'(TIME_MAX)) begin
						n.inverse_delay_mode_t = TIME_MAX;
					end else begin
						n.inverse_delay_mode_t = div_quo[TIME_W-1:0];
					end
					n.seq_op = 2'b10;
					n.div_start = 1'b1;
				end
				2'b10: begin
					n.primary  = div_quo[31:0];
					n.seq_busy = 1'b0;
				end
				default: n.seq_busy = 1'b0;
			endcase
		end
		if (n.st == ST_TIMING) begin
			n.remaining = (TIME_W+1)'(target) - (TIME_W+1)'(n.elapsed);
		end else begin
			n.remaining = '0;
		end
		if (r.ctrl[CTRL_FORCE_EN]) begin
			unique case (nov_force_t'(r.ctrl[CTRL_FORCE_LSB +: 2]))
				FORCE_NORMAL:  {n.start_o, n.trip_o, n.blocked_o} = 3'h0;
				FORCE_START:   {n.start_o, n.trip_o, n.blocked_o} = 3'h4;
				FORCE_TRIP:    {n.start_o, n.trip_o, n.blocked_o} = 3'h6;
				FORCE_BLOCKED: {n.start_o, n.trip_o, n.blocked_o} = 3'h1;
			endcase
		end else begin
			n.start_o   = (n.st == ST_TIMING) || (n.st == ST_TRIPPED);
			n.trip_o    = (n.st == ST_TRIPPED);
			n.blocked_o = (n.st == ST_BLOCKED);
		end
		// A rising event in the same cycle as a clear keeps its bit set.
		int_set    = {n.blocked_o & ~r.blocked_o, n.trip_o & ~r.trip_o, n.start_o & ~r.start_o};
		n.int_stat = (r.int_stat & ~int_clr) | int_set;
		n.irq_o    = |(n.int_stat & n.int_mask);
	end

	// State register with documented reset values.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r         <= '0;
			r.ctrl    <= CTRL_RST;
			r.thr0    <= THR_RST;
			r.thr1    <= THR_RST;
			r.dly0    <= DLY_RST;
			r.dly1    <= DLY_RST;
			r.k0      <= K_RST;
			r.k1      <= K_RST;
			r.vt_calc <= VT_RST;
			r.vt_a    <= VT_RST;
			r.vt_b    <= VT_RST;
			r.st      <= ST_IDLE;
			r.src     <= SRC_NONE;
		end else begin
			r <= n;
		end
	end

	// Output drive.
	assign avs_readdata          = r.rdata;
	assign avs_waitrequest       = (avs_read || avs_write) && !r.resp;
	assign start_out             = r.start_o;
	assign trip_out              = r.trip_o;
	assign blocked_out           = r.blocked_o;
	assign no_residual_available = (r.src == SRC_NONE);
	assign measuring_now         = r.src;
	assign irq                   = r.irq_o;

endmodule : nov_stage

/* File: bench/nov_stage_props.sv */
`timescale 1ns/1ns
module nov_stage_props import nov_pkg::*; (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        reset,
	// Register bus.
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Stage outputs.
	input wire logic        start_out,
	input wire logic        trip_out,
	input wire logic        blocked_out,
	input wire logic        no_residual_available,
	input wire logic [1:0]  measuring_now
);
	// Every check runs on the one clock and stands aside during reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// A request is held while it waits, then answered one cycle later.
	sequence req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence answered;
		##1 !avs_waitrequest;
	endsequence

	wait_once_a: assert property (req_wait |-> answered)
		else $error("bus wait not one cycle");
	idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	rd_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without read");
	blk_excl_a: assert property (blocked_out |-> !start_out && !trip_out)
		else $error("blocked with start or trip");
	nores_code_a: assert property (no_residual_available == (measuring_now == 2'h0))
		else $error("no residual flag disagrees with channel");
	trip_start_a: assert property (trip_out |-> start_out)
		else $error("trip without start");
	trip_late_a: assert property ($rose(trip_out) && !$rose(start_out) |-> $past(start_out))
		else $error("trip rose without prior start");
	start_hold_a: assert property ($rose(start_out) |=> start_out)
		else $error("start dropped at once");
endmodule : nov_stage_props

bind nov_stage nov_stage_props i_props (.clk(clk), .reset(reset), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
	.no_residual_available(no_residual_available), .measuring_now(measuring_now));

/* File: bench/nov_vfe.sv */
`timescale 1ns/1ns
module nov_vfe import nov_pkg::*; (
	// Clock and reset.
	input wire logic               clk,
	input wire logic               reset,
	// Wanted levels.
	input wire logic [PH_W-1:0]   fault_re,
	input wire logic [MEAS_W-1:0] res_a,
	input wire logic [MEAS_W-1:0] res_b,
	// Measured values.
	output logic [PH_W-1:0]       ul1_re,
	output logic [PH_W-1:0]       ul1_im,
	output logic [PH_W-1:0]       ul2_re,
	output logic [PH_W-1:0]       ul2_im,
	output logic [PH_W-1:0]       ul3_re,
	output logic [PH_W-1:0]       ul3_im,
	output logic [MEAS_W-1:0]     aux_channel_a,
	output logic [MEAS_W-1:0]     aux_channel_b
);
	// fundamental phasors only
	// Phases two and three cancel, so the residual is the first phase alone.
	assign ul1_im = 16'h0000;
	assign ul2_re = 16'hef16;
	assign ul2_im = 16'hf63c;
	assign ul3_re = 16'h10ea;
	assign ul3_im = 16'h09c4;

	// fundamental magnitudes registered
	// Levels are registered so they never move in the middle of a cycle.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ul1_re        <= '0;
			aux_channel_a <= '0;
			aux_channel_b <= '0;
		end else begin
			ul1_re        <= fault_re;
			aux_channel_a <= res_a;
			aux_channel_b <= res_b;
		end
	end
endmodule : nov_vfe

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top import nov_pkg::*;;
	localparam int TK = 200;
	localparam logic [31:0] MEAS_EXP = (32'd6000 * INV_SQRT3) >> INV_SHIFT;
	localparam logic [2:0] FEXP [4] = '{3'b000, 3'b001, 3'b011, 3'b100};
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = '0;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic [PH_W-1:0]   ul1_re, ul1_im, ul2_re, ul2_im, ul3_re, ul3_im;
	logic [MEAS_W-1:0] aux_channel_a, aux_channel_b;
	logic              block_in = 1'b0;
	logic              start_out, trip_out, blocked_out, no_residual_available, irq;
	logic [1:0]        measuring_now;
	logic [PH_W-1:0]   flt = '0;
	logic [MEAS_W-1:0] ra = '0;
	logic [MEAS_W-1:0] rb = '0;
	int                err_total = 0;
	int                checked = 0;

	nov_stage #(.CYCLE_CLKS_P(TK)) i_dut (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ul1_re(ul1_re),
		.ul1_im(ul1_im), .ul2_re(ul2_re), .ul2_im(ul2_im), .ul3_re(ul3_re), .ul3_im(ul3_im),
		.aux_channel_a(aux_channel_a), .aux_channel_b(aux_channel_b), .block_in(block_in),
		.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
		.no_residual_available(no_residual_available), .measuring_now(measuring_now),
		.irq(irq));

	nov_vfe i_vfe (.clk(clk), .reset(reset), .fault_re(flt), .res_a(ra), .res_b(rb),
		.ul1_re(ul1_re), .ul1_im(ul1_im), .ul2_re(ul2_re), .ul2_im(ul2_im), .ul3_re(ul3_re),
		.ul3_im(ul3_im), .aux_channel_a(aux_channel_a), .aux_channel_b(aux_channel_b));

	// Free-running 250 MHz clock.
	always #2 clk = ~clk;

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// One bus cycle; the request stands until waitrequest is sampled low at a rising edge.
	task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : xfer

	task bw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : bw

	task rc(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, avs_readdata, e);
	endtask : rc

	task tk(input int n);
		repeat (n * TK) @(negedge clk);
	endtask : tk

	task si(input int a, input int b, input int f, input logic blk);
		@(posedge clk);
		ra <= MEAS_W'(a);
		rb <= MEAS_W'(b);
		flt <= PH_W'(f);
		block_in <= blk;
	endtask : si

	task wst;
		for (int i = 0; i < 3 * TK && start_out !== 1'b1; i++) @(negedge clk);
	endtask : wst

	task give_verdict;
		$display("Checks made %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	// Cuts a hang short well after the tests should have ended.
	initial begin
		repeat (150 * TK) @(posedge clk);
		err_total++;
		give_verdict();
	end

	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rc("ctrl", REG_CTRL, 32'h80);
		rc("thr", REG_THR_G0, 32'h7d0);
		rc("dly", REG_DLY_G0, 32'h8);
		rc("unmapped", 8'h4c, 32'h0);
		rc("status", REG_STATUS, 32'h100);
		bw(REG_INT_MASK, 32'h7);
		$display("test reset done");
		si(0, 0, 6000, 1'b0);
		wst();
		chk("mnow", measuring_now, 32'h1);
		repeat (TK / 2) @(negedge clk);
		rc("remaining", REG_REMAINING, 32'h8);
		rc("meas", REG_MEAS, MEAS_EXP);
		rc("ratio", REG_RATIO, MEAS_EXP * 100 / 2000);
		repeat (7 * TK) @(negedge clk);
		chk("trip", trip_out, 1'b0);
		rc("remaining", REG_REMAINING, 32'h1);
		rc("primary", REG_PRIMARY, 32'd20000);
		tk(1);
		chk("trip", trip_out, 1'b1);
		chk("irq", irq, 1'b1);
		rc("int", REG_INT_STAT, 32'h3);
		bw(REG_INT_STAT, 32'h3);
		tk(1);
		chk("irq", irq, 1'b0);
		$display("test delay done");
		si(1950, 0, 0, 1'b0);
		bw(REG_CTRL, 32'ha2);
		tk(2);
		chk("mnow", measuring_now, 32'h2);
		chk("start", start_out, 1'b1);
		si(1939, 0, 0, 1'b0);
		tk(2);
		chk("start", start_out, 1'b0);
		si(2000, 0, 0, 1'b0);
		tk(2);
		chk("start", start_out, 1'b0);
		si(2001, 0, 0, 1'b0);
		tk(2);
		chk("start", start_out, 1'b1);
		$display("test hysteresis done");
		si(0, 2500, 0, 1'b0);
		bw(REG_CTRL, 32'h83);
		tk(2);
		chk("nores", no_residual_available, 1'b1);
		bw(REG_CTRL, 32'h00);
		tk(2);
		chk("nores", no_residual_available, 1'b1);
		bw(REG_CTRL, 32'hc3);
		tk(2);
		chk("mnow", measuring_now, 32'h3);
		$display("test source done");
		bw(REG_THR_G1, 32'h1388);
		bw(REG_DLY_G1, 32'h0);
		bw(REG_GROUP, 32'h1);
		tk(2);
		chk("start", start_out, 1'b0);
		rc("ctrl", REG_CTRL, 32'hc3);
		rc("primary", REG_PRIMARY, 32'd50000);
		si(0, 5001, 0, 1'b0);
		wst();
		chk("trip", trip_out, 1'b1);
		$display("test group done");
		si(0, 0, 0, 1'b0);
		tk(2);
		si(0, 6000, 0, 1'b1);
		tk(2);
		chk("blocked", {start_out, blocked_out}, 32'h1);
		si(0, 6000, 0, 1'b0);
		tk(2);
		for (int f = 0; f < 4; f++) begin
			bw(REG_CTRL, 32'hd3 | (f << 2));
			tk(1);
			chk("forced", {blocked_out, trip_out, start_out}, FEXP[f]);
		end
		bw(REG_CTRL, 32'hcf);
		tk(1);
		chk("unforced", {blocked_out, trip_out, start_out}, 32'h4);
		$display("test force done");
		bw(REG_CTRL, 32'h1c3);
		tk(3);
		rc("expected", REG_EXPECTED, 32'd50);
		si(0, 7500, 0, 1'b0);
		tk(3);
		rc("expected", REG_EXPECTED, 32'd20);
		$display("test inverse done");
		give_verdict();
	end
endmodule : tb_top
